// >>> design/irq_sticky.sv
// sticky interrupt status with enable register and write-one-to-clear
// assumes event pulses and write strobes on the same clock
module irq_sticky
	import timer_cc_pkg::*;
(
	input  wire logic             sys_clk_i,
	input  wire logic             srst_i,
	input  wire logic [IRQ_W-1:0] event_i,
	input  wire logic             clr_we_i,
	input  wire logic             en_we_i,
	input  wire logic [IRQ_W-1:0] wdata_i,
	output logic      [IRQ_W-1:0] status_o,
	output logic      [IRQ_W-1:0] enable_o,
	output logic                  irq_o
);

	logic [IRQ_W-1:0] status_r;
	logic [IRQ_W-1:0] enable_r;

	// a set in the clearing cycle wins
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~(clr_we_i ? wdata_i : '0)) | event_i;
		end
	end

	// enable register
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			enable_r <= '0;
		end else if (en_we_i) begin
			enable_r <= wdata_i;
		end
	end

	assign status_o = status_r;
	assign enable_o = enable_r;
	assign irq_o    = |(status_r & enable_r);

endmodule

// >>> design/pin_edge_sync.sv
// two-flop synchroniser for one pin, with a selectable edge detector
// assumes the pin is asynchronous to sys_clk_i
module pin_edge_sync
	import timer_cc_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic       pin_i,
	input  wire logic [1:0] edge_sel_i,
	output logic            level_o,
	output logic            edge_o
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// first flop feeds only the second
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;

	// edge decode on the synchronised level
	always_comb begin
		case (edge_sel_i)
			EDGE_RISE: edge_o = sync_r & ~prev_r;
			EDGE_FALL: edge_o = ~sync_r & prev_r;
			EDGE_BOTH: edge_o = sync_r ^ prev_r;
			default:   edge_o = 1'b0;
		endcase
	end

endmodule

// >>> design/timer_cc_pkg.sv
// constants shared by the timer channel: register map, field positions, codes
// assumes a 40 MHz system clock and a 32-bit apb bus with byte addresses
package timer_cc_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL_ZERO_OFS = 8'h00;
	localparam logic [7:0] MODE_ONE_OFS  = 8'h04;
	localparam logic [7:0] CC_TWO_OFS    = 8'h08;
	localparam logic [7:0] COUNT_OFS     = 8'h0C;
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
	localparam logic [7:0] IRQ_CLR_OFS   = 8'h14;
	localparam logic [7:0] IRQ_EN_OFS    = 8'h18;

	// control register fields
	localparam int unsigned CE_BIT       = 0;
	localparam int unsigned CCS_BIT      = 1;
	localparam int unsigned TOE_BIT      = 2;
	localparam int unsigned CAP_EDGE_LSB = 4;
	localparam int unsigned EVT_EDGE_LSB = 6;
	localparam logic [7:0]  CTRL_MASK    = 8'hF7;
	localparam logic [7:0]  CTRL_RST     = 8'h00;

	// mode control register fields, compare reset value and counter maximum
	localparam int unsigned MODE_LSB     = 0;
	localparam int unsigned EEE_BIT      = 5;
	localparam int unsigned EST_BIT      = 6;
	localparam logic [7:0]  MODE_MASK    = 8'h27;
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [15:0] CC_RST       = 16'h0000;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;

	// mode field codes
	localparam logic [2:0] MD_INTERVAL  = 3'h0;
	localparam logic [2:0] MD_EXT_EVENT = 3'h1;
	localparam logic [2:0] MD_EXT_TRIG  = 3'h2;
	localparam logic [2:0] MD_ONE_SHOT  = 3'h4;
	localparam logic [2:0] MD_FREE_RUN  = 3'h5;
	localparam logic [2:0] MD_PULSE_W   = 3'h6;

	// edge select codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// interrupt status bits
	localparam int unsigned IRQ_W     = 3;
	localparam int unsigned IRQ_MATCH = 0;
	localparam int unsigned IRQ_CAPT  = 1;
	localparam int unsigned IRQ_OVF   = 2;

	typedef enum logic {ST_IDLE, ST_RUN} run_state_e;

endpackage

// >>> design/timer_cc_top.sv
// 16-bit timer channel with mode control and one capture/compare register
// assumes an apb master on sys_clk_i and asynchronous event and capture pins

module timer_cc_top
	import timer_cc_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	input  wire logic        ext_event_i,
	input  wire logic        capture_trigger_input_i,
	input  wire logic        slow_clock_i,
	output logic             timer_output_pin_o,
	output logic             compare_match_interrupt_o,
	output logic             irq_o
);

	// mode decode used by several paths
	function automatic logic is_compare_use(input logic [2:0] mode, input logic ccs);
		logic res;
		res = 1'b1;
		if (mode == MD_PULSE_W) begin
			res = 1'b0;
		end else if (mode == MD_FREE_RUN) begin
			res = ~ccs;
		end
		return res;
	endfunction

	function automatic logic is_pulse_mode(input logic [2:0] mode);
		return (mode == MD_EXT_TRIG) || (mode == MD_ONE_SHOT);
	endfunction

	// true for every offset that answers without an error
	function automatic logic is_mapped(input logic [7:0] addr);
		logic hit;
		hit = 1'b0;
		case (addr)
			CTRL_ZERO_OFS, MODE_ONE_OFS, CC_TWO_OFS, COUNT_OFS: hit = 1'b1;
			IRQ_STAT_OFS, IRQ_CLR_OFS, IRQ_EN_OFS:              hit = 1'b1;
			default:                                             hit = 1'b0;
		endcase
		return hit;
	endfunction

	logic [7:0]       ctrl_r;
	logic [7:0]       mode_one_r;
	logic [15:0]      cc_r;
	logic [15:0]      shadow_r;
	logic [15:0]      cnt_r;
	logic [31:0]      rdata_r;
	logic             stuck_r;
	logic             tout_r;
	logic             match_r;
	run_state_e       run_r;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_events;

	logic       evt_edge;
	logic       cap_edge;
	logic       slow_level;
	logic [2:0] mode;
	logic       ce;
	logic       compare_use;
	logic       capture_use;
	logic       ce_prev_r;

	assign mode        = mode_one_r[MODE_LSB +: 3];
	assign ce          = ctrl_r[CE_BIT];
	assign compare_use = is_compare_use(mode, ctrl_r[CCS_BIT]);
	assign capture_use = ~is_compare_use(mode, ctrl_r[CCS_BIT]);

	// pin synchronisers
	pin_edge_sync u_evt_sync (
		.sys_clk_i  (sys_clk_i),
		.srst_i     (srst_i),
		.pin_i      (ext_event_i),
		.edge_sel_i (ctrl_r[EVT_EDGE_LSB +: 2]),
		.level_o    (),
		.edge_o     (evt_edge)
	);

	pin_edge_sync u_cap_sync (
		.sys_clk_i  (sys_clk_i),
		.srst_i     (srst_i),
		.pin_i      (capture_trigger_input_i),
		.edge_sel_i (ctrl_r[CAP_EDGE_LSB +: 2]),
		.level_o    (),
		.edge_o     (cap_edge)
	);

	pin_edge_sync u_slow_sync (
		.sys_clk_i  (sys_clk_i),
		.srst_i     (srst_i),
		.pin_i      (slow_clock_i),
		.edge_sel_i (EDGE_NONE),
		.level_o    (slow_level),
		.edge_o     ()
	);

	// ---- bus decode
	logic setup_ph;
	logic access_ph;
	logic cc_addr;
	logic mapped;
	logic bad_strb;
	logic wr_ok;

	assign setup_ph  = psel_i & ~penable_i;
	assign access_ph = psel_i & penable_i;
	assign cc_addr   = (paddr_i == CC_TWO_OFS);
	assign mapped    = is_mapped(paddr_i);
	// the compare register only takes whole 16-bit writes
	assign bad_strb  = pwrite_i & cc_addr & (pstrb_i[1:0] != 2'h3);

	// a wait on the slow clock never completes until reset
	assign pready_o  = ~stuck_r & ~(access_ph & cc_addr & slow_level);
	assign pslverr_o = access_ph & pready_o & (~mapped | bad_strb);
	assign wr_ok     = access_ph & pready_o & pwrite_i & mapped & ~bad_strb;

	// per-register write strobes, one decode shared by every writer
	logic wr_ctrl;
	logic wr_mode;
	logic wr_cc;
	logic wr_irq_clr;
	logic wr_irq_en;

	assign wr_ctrl    = wr_ok & (paddr_i == CTRL_ZERO_OFS) & pstrb_i[0];
	assign wr_mode    = wr_ok & (paddr_i == MODE_ONE_OFS) & pstrb_i[0];
	assign wr_cc      = wr_ok & cc_addr;
	assign wr_irq_clr = wr_ok & (paddr_i == IRQ_CLR_OFS) & pstrb_i[0];
	assign wr_irq_en  = wr_ok & (paddr_i == IRQ_EN_OFS) & pstrb_i[0];

	// stuck wait latch, cleared by reset only
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			stuck_r <= 1'b0;
		end else if (psel_i & cc_addr & slow_level) begin
			stuck_r <= 1'b1;
		end
	end

	// read data captured in the setup cycle, so a capture in the access cycle
	// cannot tear the word being returned
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (setup_ph & ~pwrite_i) begin
			case (paddr_i)
				CTRL_ZERO_OFS: rdata_r <= {24'h00_0000, ctrl_r};
				MODE_ONE_OFS:  rdata_r <= {24'h00_0000, mode_one_r};
				CC_TWO_OFS:    rdata_r <= {16'h0000, cc_r};
				COUNT_OFS:     rdata_r <= {16'h0000, cnt_r};
				IRQ_STAT_OFS:  rdata_r <= {29'h0000_0000, irq_status};
				IRQ_EN_OFS:    rdata_r <= {29'h0000_0000, irq_enable};
				default:       rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata_o = rdata_r;

	// ---- control registers
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata_i[7:0] & CTRL_MASK;
		end
	end

	// mode register; reserved bits stay zero, trigger bit is write-action only
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mode_one_r <= MODE_RST;
		end else if (wr_mode) begin
			mode_one_r <= pwdata_i[7:0] & MODE_MASK;
		end
	end

	// software trigger is honoured only in the two pulse modes
	logic sw_trig;
	logic hw_trig;
	logic trig;
	assign sw_trig = wr_mode & pwdata_i[EST_BIT] & is_pulse_mode(mode);
	assign hw_trig = (mode == MD_EXT_TRIG) & cap_edge;
	assign trig    = ce & (sw_trig | hw_trig);

	// ---- count source and run state
	logic tick;
	logic running;
	logic at_match;
	logic clr_on_match;
	logic cap_hit;
	logic ovf_hit;
	logic reload;

	// event count mode ignores the enable bit and always uses the pin
	assign tick = ((mode == MD_EXT_EVENT) || mode_one_r[EEE_BIT]) ? evt_edge : 1'b1;
	assign running = ce & (~is_pulse_mode(mode) | (run_r == ST_RUN));
	assign at_match = running & tick & compare_use & (cnt_r == shadow_r);
	assign clr_on_match = (mode != MD_FREE_RUN);
	// capture in free-run select or pulse width mode
	assign cap_hit = ce & capture_use & cap_edge;
	assign ovf_hit = running & tick & (cnt_r == CNT_MAX) & ~(at_match & clr_on_match);
	assign reload  = (at_match & clr_on_match) | ovf_hit | trig;

	// pulse modes wait for a trigger; one-shot stops after its match
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			run_r <= ST_IDLE;
		end else begin
			case (run_r)
				ST_IDLE: begin
					if (trig) begin
						run_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (~ce) begin
						run_r <= ST_IDLE;
					end else if (at_match && mode == MD_ONE_SHOT && !trig) begin
						run_r <= ST_IDLE;
					end
				end
				default: run_r <= ST_IDLE;
			endcase
		end
	end

	// the 16-bit counter; stopping clears it so restarting recovers cleanly
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt_r <= 16'h0000;
		end else if (~ce) begin
			cnt_r <= 16'h0000;
		end else if (trig) begin
			cnt_r <= 16'h0000;
		end else if (cap_hit && mode == MD_PULSE_W) begin
			cnt_r <= 16'h0000;
		end else if (at_match && clr_on_match) begin
			cnt_r <= 16'h0000;
		end else if (running && tick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ---- capture/compare register; a capture takes priority over a write
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cc_r <= CC_RST;
		end else if (cap_hit) begin
			cc_r <= cnt_r;
		end else if (wr_cc) begin
			cc_r <= pwdata_i[15:0];
		end
	end

	// in compare use, shadow buffer follows the register while stopped, else at each reload
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			shadow_r <= CC_RST;
		end else if (compare_use && (~ce || reload)) begin
			shadow_r <= cc_r;
		end
	end

	// ---- compare outputs
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			match_r <= 1'b0;
		end else begin
			match_r <= at_match;
		end
	end

	assign compare_match_interrupt_o = match_r;

	// timer output toggles on match when enabled
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			tout_r <= 1'b0;
		end else if (at_match && ctrl_r[TOE_BIT]) begin
			tout_r <= ~tout_r;
		end
	end

	assign timer_output_pin_o = tout_r;

	// track count enable for the interrupt unit's idea of restart
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ce_prev_r <= 1'b0;
		end else begin
			ce_prev_r <= ce;
		end
	end

	// ---- interrupt status, enable and clear
	always_comb begin
		irq_events            = '0;
		irq_events[IRQ_MATCH] = at_match;
		irq_events[IRQ_CAPT]  = cap_hit;
		irq_events[IRQ_OVF]   = ovf_hit & ce_prev_r;
	end

	irq_sticky u_irq (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.event_i   (irq_events),
		.clr_we_i  (wr_irq_clr),
		.en_we_i   (wr_irq_en),
		.wdata_i   (pwdata_i[IRQ_W-1:0]),
		.status_o  (irq_status),
		.enable_o  (irq_enable),
		.irq_o     (irq_o)
	);

endmodule

// >>> verification/pin_partner.sv
// partner model of the event, capture and slow clock pins
// assumes tasks are called from the bench on the sys_clk_i domain
module pin_partner
(
	input  wire logic sys_clk_i,
	output logic      ext_event_o,
	output logic      capture_o,
	output logic      slow_clock_o
);
	// pins idle low
	initial begin
		ext_event_o = 1'b0;
		capture_o = 1'b0;
		slow_clock_o = 1'b0;
	end

	// one pulse on a pin; hold sets how slowly the far side moves
	task automatic pulse(input logic on_cap, input int hold);
		@(posedge sys_clk_i);
		if (on_cap)
			capture_o <= 1'b1;
		else
			ext_event_o <= 1'b1;
		repeat (hold) @(posedge sys_clk_i);
		capture_o <= 1'b0;
		ext_event_o <= 1'b0;
		repeat (hold) @(posedge sys_clk_i);
	endtask

	// slow clock source level seen by the block
	task automatic set_slow(input logic v);
		@(posedge sys_clk_i);
		slow_clock_o <= v;
	endtask
endmodule

// >>> verification/test_timer_mode_and_capture_compare.sv
// bench for the timer channel: apb tasks, pin scenarios, verdict
// assumes the package, timer_cc_top, pin_partner and the checker are compiled first
module test_timer_mode_and_capture_compare
	import timer_cc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, srst, sel, ena, wrt, rdy, err, irq, mp, pin, evt, cap, slow, lok, lerr;
	logic [7:0]  adr;
	logic [31:0] wd, rdat, rv, cv;
	logic [3:0]  stb;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc = 0;
	int          nc;

	timer_cc_top timer_cc_top_inst (.sys_clk_i(clk), .srst_i(srst), .psel_i(sel), .penable_i(ena),
		.pwrite_i(wrt), .paddr_i(adr), .pwdata_i(wd), .pstrb_i(stb), .pready_o(rdy), .prdata_o(rdat),
		.pslverr_o(err), .ext_event_i(evt), .capture_trigger_input_i(cap), .slow_clock_i(slow),
		.timer_output_pin_o(pin), .compare_match_interrupt_o(mp), .irq_o(irq));
	pin_partner pin_partner_inst (.sys_clk_i(clk), .ext_event_o(evt), .capture_o(cap), .slow_clock_o(slow));

	// free running clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one apb transfer; waits for pready; lok tells if it came with no wait state
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		sel <= 1'b1;
		wrt <= w;
		adr <= a;
		wd <= d;
		stb <= s;
		@(posedge clk);
		ena <= 1'b1;
		@(posedge clk);
		lok = rdy;
		while (rdy !== 1'b1)
			@(posedge clk);
		rv = rdat;
		lerr = err;
		sel <= 1'b0;
		ena <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic do_reset();
		srst <= 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
	endtask

	// cycles until the match pulse, zero if none within lim
	task automatic wait_match(input int lim, output int n);
		n = 0;
		for (int i = 1; i <= lim && n == 0; i++) begin
			@(posedge clk);
			if (mp === 1'b1)
				n = i;
		end
	endtask

	task automatic t_regs();
		logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
		bus(1'b0, MODE_ONE_OFS, 32'h0, 4'hF);
		chk("mode reset", rv, 32'h0);
		foreach (codes[i]) begin
			wr(MODE_ONE_OFS, 32'h00000020 | codes[i]);
			bus(1'b0, MODE_ONE_OFS, 32'h0, 4'h1);
			chk("mode code", rv, 32'h00000020 | codes[i]);
		end
		bus(1'b1, CC_TWO_OFS, 32'h0000ABCD, 4'h1);
		chk("cc half write err", {31'h0, lerr}, 32'h1);
		bus(1'b0, CC_TWO_OFS, 32'h0, 4'hF);
		chk("cc reset", rv, 32'h0);
		bus(1'b0, 8'h1C, 32'h0, 4'hF);
		chk("unmapped err", {lerr, rv[30:0]}, 32'h80000000);
		wr(MODE_ONE_OFS, 32'h0);
		$display("regs test done");
	endtask

	task automatic t_interval();
		logic p0;
		wr(CC_TWO_OFS, 32'h2);
		wr(IRQ_EN_OFS, 32'h1);
		wr(CTRL_ZERO_OFS, 32'h5);
		wait_match(40, nc);
		p0 = pin;
		wait_match(40, nc);
		chk("match period", nc, 32'd3);
		chk("pin toggle", {31'h0, pin}, {31'h0, ~p0});
		chk("irq raised", {31'h0, irq}, 32'h1);
		wr(CC_TWO_OFS, 32'h4);
		wait_match(40, nc);
		wait_match(40, nc);
		chk("rewritten period", nc, 32'd5);
		wr(CTRL_ZERO_OFS, 32'h0);
		bus(1'b0, IRQ_STAT_OFS, 32'h0, 4'hF);
		chk("match status", rv, 32'h1);
		wr(IRQ_EN_OFS, 32'h0);
		@(posedge clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(IRQ_EN_OFS, 32'h1);
		wr(IRQ_CLR_OFS, 32'h1);
		@(posedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("interval test done");
	endtask

	task automatic t_trigger();
		wr(CC_TWO_OFS, 32'h3);
		wr(MODE_ONE_OFS, 32'h4);
		wr(CTRL_ZERO_OFS, 32'h1);
		wait_match(30, nc);
		chk("idle before trigger", nc, 32'd0);
		wr(MODE_ONE_OFS, 32'h44);
		wait_match(30, nc);
		chk("triggered", {31'h0, nc > 0 && nc < 12}, 32'h1);
		wait_match(30, nc);
		chk("single shot", nc, 32'd0);
		$display("trigger test done");
	endtask

	task automatic t_event();
		wr(CTRL_ZERO_OFS, 32'h0);
		wr(CC_TWO_OFS, 32'hFF);
		wr(MODE_ONE_OFS, 32'h1);
		wr(CTRL_ZERO_OFS, 32'h41);
		repeat (3) pin_partner_inst.pulse(1'b0, 4);
		bus(1'b0, COUNT_OFS, 32'h0, 4'hF);
		chk("event count", rv, 32'h3);
		$display("event test done");
	endtask

	task automatic t_capture();
		wr(CTRL_ZERO_OFS, 32'h0);
		wr(MODE_ONE_OFS, 32'h5);
		wr(CTRL_ZERO_OFS, 32'h13);
		repeat (20) @(posedge clk);
		pin_partner_inst.pulse(1'b1, 4);
		bus(1'b0, CC_TWO_OFS, 32'h0, 4'hF);
		cv = rv;
		bus(1'b0, COUNT_OFS, 32'h0, 4'hF);
		chk("free run capture", {31'h0, cv > 32'h14 && cv < rv}, 32'h1);
		wr(CTRL_ZERO_OFS, 32'h0);
		wr(MODE_ONE_OFS, 32'h6);
		wr(CTRL_ZERO_OFS, 32'h11);
		repeat (40) @(posedge clk);
		pin_partner_inst.pulse(1'b1, 4);
		bus(1'b0, CC_TWO_OFS, 32'h0, 4'hF);
		cv = rv;
		bus(1'b0, COUNT_OFS, 32'h0, 4'hF);
		chk("width capture", {31'h0, cv > 32'h28 && rv < 32'h20}, 32'h1);
		wr(CTRL_ZERO_OFS, 32'h0);
		$display("capture test done");
	endtask

	task automatic t_stuck();
		pin_partner_inst.set_slow(1'b1);
		repeat (4) @(posedge clk);
		// hand-driven read that must never be answered; only reset ends it
		sel <= 1'b1;
		wrt <= 1'b0;
		adr <= CC_TWO_OFS;
		stb <= 4'h0;
		@(posedge clk);
		ena <= 1'b1;
		nc = 0;
		repeat (20) begin
			@(posedge clk);
			if (rdy !== 1'b0)
				nc++;
		end
		chk("wait pending", nc, 32'd0);
		pin_partner_inst.set_slow(1'b0);
		sel <= 1'b0;
		ena <= 1'b0;
		do_reset();
		bus(1'b0, MODE_ONE_OFS, 32'h0, 4'hF);
		chk("wait released", {31'h0, lok}, 32'h1);
		chk("mode after reset", rv, 32'h0);
		$display("stuck test done");
	endtask

	// main sequence
	initial begin
		srst = 1'b1;
		sel = 1'b0;
		ena = 1'b0;
		wrt = 1'b0;
		adr = 8'h00;
		wd = 32'h0;
		stb = 4'h0;
		do_reset();
		t_regs();
		t_interval();
		t_trigger();
		t_event();
		t_capture();
		t_stuck();
		tally_and_finish();
	end
endmodule

bind timer_cc_top timer_cc_checker timer_cc_checker_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pstrb_i(pstrb_i),
	.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .timer_output_pin_o(timer_output_pin_o),
	.compare_match_interrupt_o(compare_match_interrupt_o));

// >>> verification/timer_cc_checker.sv
// checker of bus answers, register widths and compare outputs
// assumes it is bound to timer_cc_top and sees only its ports
module timer_cc_checker
	import timer_cc_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic        timer_output_pin_o,
	input wire logic        compare_match_interrupt_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	logic acc;

	// access phase of a transfer
	assign acc = psel_i && penable_i;

	a_zero_wait: assert property (acc && paddr_i != CC_TWO_OFS && $past(pready_o) |-> pready_o)
		else $error("access not answered at once");
	a_stuck_held: assert property (!pready_o |=> !pready_o)
		else $error("pending wait ended without reset");
	a_ready_rst: assert property ($fell(srst_i) |-> pready_o)
		else $error("wait not released by reset");
	a_strobe_err: assert property (acc && pready_o && pwrite_i && paddr_i == CC_TWO_OFS
		&& pstrb_i[1:0] != 2'h3 |-> pslverr_o)
		else $error("partial word write accepted");
	a_mode_ok: assert property (acc && pready_o && paddr_i == MODE_ONE_OFS && pstrb_i[0] |-> !pslverr_o)
		else $error("mode byte access refused");
	a_mode_bits: assert property (acc && !pwrite_i && paddr_i == MODE_ONE_OFS
		|-> (prdata_o & 32'hFFFFFFD8) == 32'h00000000)
		else $error("mode read shows extra bits");
	a_cc_width: assert property (acc && !pwrite_i && paddr_i == CC_TWO_OFS |-> prdata_o[31:16] == 16'h0000)
		else $error("compare read wider than a word");
	a_pulse_one: assert property (compare_match_interrupt_o |=> !compare_match_interrupt_o)
		else $error("match pulse longer than one cycle");
	a_pin_cause: assert property ($changed(timer_output_pin_o) |-> compare_match_interrupt_o)
		else $error("output pin moved without a match");
endmodule
